// ===== verilog/dias_pkg.sv
// Purpose: shared constants and types of the interleaved access sequencer
// Assumes: 100 MHz system clock, strobes modelled active high
// Notes:   half-clock strobe edges are rounded to whole clocks
package dias_pkg;

  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 16;

  // interleave type codes, one 2-bit field per bank pair
  localparam logic [1:0] ILV_NONE  = 2'h0;
  localparam logic [1:0] ILV_XCVR  = 2'h1;
  localparam logic [1:0] ILV_LATCH = 2'h2;
  localparam logic [1:0] ILV_REG   = 2'h3;
  localparam int         ILV_PAIR0 = 0;
  localparam int         ILV_PAIR1 = 2;

  // access size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_TRI  = 2'h2;
  localparam logic [1:0] SIZE_WORD = 2'h3;

  // last word index of each transfer shape
  localparam logic [2:0] LAST_ONE    = 3'h0;
  localparam logic [2:0] LAST_TWO    = 3'h1;
  localparam logic [2:0] LAST_BURST4 = 3'h3;
  localparam logic [2:0] LAST_BURST8 = 3'h7;

  // column address steps
  localparam logic [ADDR_W-1:0] STEP_16 = 26'h0000002;
  localparam logic [ADDR_W-1:0] STEP_32 = 26'h0000004;

  // timing
  localparam int T_CLK_NS    = 10;
  localparam int T_CAS_NS    = 20;
  localparam int CAS_CYC     = (T_CAS_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam logic [1:0] CAS_LAST = 2'(CAS_CYC - 1);

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
  localparam logic [3:0]        STRB_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_LATCH,
    ST_END
  } dias_state_t;

endpackage : dias_pkg

// ===== verilog/dias_fifo.sv
// Purpose: write data buffer between requester and sequencer
// Assumes: single clock, registered ready and valid flags
// Notes:   storage is flip-flops, no reset on data
`timescale 1ns/100ps
`default_nettype none
module dias_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_count;
  logic             next_in_ready;
  logic             next_out_valid;
  logic             push;
  logic             pop;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    push           = in_valid_i && in_ready_o;
    pop            = out_ready_i && out_valid_o;
    next_wr_ptr    = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr    = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_count     = count;
    if (push && !pop) begin
      next_count = (PW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (PW+1)'(count - 1'b1);
    end
    next_in_ready  = next_count != (PW+1)'(DEPTH);
    next_out_valid = next_count != '0;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      in_ready_o  <= next_in_ready;
      out_valid_o <= next_out_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one storage word per entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge ref_clk_i) begin
      if (push && wr_ptr == PW'(g)) begin
        mem[g] <= in_data_i;
      end
    end
  end

  assign out_data_o = mem[rd_ptr];

endmodule : dias_fifo
`default_nettype wire

// ===== verilog/dias_seq.sv
// Purpose: page-mode multi-datum and interleaved read sequencer
// Assumes: strobes active high, one request at a time while busy_o
// Notes:   write data passes through a 16-word buffer
`timescale 1ns/100ps
`default_nettype none
module dias_seq (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        req_i,
  input  wire logic                        req_write_i,
  input  wire logic                        req_port16_i,
  input  wire logic [1:0]                  req_size_i,
  input  wire logic                        req_burst_i,
  input  wire logic [1:0]                  req_bank_i,
  input  wire logic [3:0]                  req_byte_en_i,
  input  wire logic [dias_pkg::ADDR_W-1:0] req_row_i,
  input  wire logic [dias_pkg::ADDR_W-1:0] req_col_i,
  input  wire logic [3:0]                  interleave_type_i,
  input  wire logic [dias_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                        wr_valid_i,
  output logic                             wr_ready_o,
  input  wire logic [dias_pkg::DATA_W-1:0] dram_data_i,
  output logic                             busy_o,
  output logic [3:0]                       row_strobe_o,
  output logic [3:0]                       column_strobe_o,
  output logic [dias_pkg::ADDR_W-1:0]      system_address_bus_o,
  output logic [dias_pkg::DATA_W-1:0]      system_data_bus_o,
  output logic                             data_out_en_o,
  output logic                             burst_frame_o,
  output logic                             data_ready_o,
  output logic [dias_pkg::DATA_W-1:0]      read_data_o,
  output logic                             read_valid_o,
  output logic                             even_bank_read_enable_o,
  output logic                             odd_bank_read_enable_o,
  output logic                             even_bank_write_enable_o,
  output logic                             odd_bank_write_enable_o
);

  dias_pkg::dias_state_t         state;
  dias_pkg::dias_state_t         next_state;
  logic [1:0]                    cnt;
  logic [1:0]                    next_cnt;
  logic [2:0]                    word;
  logic [2:0]                    next_word;
  logic [2:0]                    last;
  logic [2:0]                    next_last;
  logic [dias_pkg::ADDR_W-1:0]   col;
  logic [dias_pkg::ADDR_W-1:0]   next_col;
  logic [1:0]                    bank;
  logic [1:0]                    next_bank;
  logic [1:0]                    mode;
  logic [1:0]                    next_mode;
  logic [3:0]                    byte_en;
  logic [3:0]                    next_byte_en;
  logic                          wr;
  logic                          next_wr;
  logic                          p16;
  logic                          next_p16;
  logic                          pmode;
  logic                          next_pmode;
  logic                          skip;
  logic                          next_skip;
  logic                          pop;
  logic                          sample;
  logic                          advance;
  logic                          latched;
  logic [1:0]                    req_mode;
  logic [dias_pkg::ADDR_W-1:0]   step;
  logic [dias_pkg::DATA_W-1:0]   fifo_data;
  logic                          fifo_valid;
  logic                          n_dp;
  logic                          n_cas;
  logic                          n_odd;
  logic [3:0]                    row_sel;
  logic                          next_busy;
  logic [3:0]                    next_cas_o;
  logic [dias_pkg::ADDR_W-1:0]   next_addr_o;
  logic [dias_pkg::DATA_W-1:0]   next_data_o;
  logic                          next_frame;
  logic                          next_ready;
  logic                          next_rvalid;
  logic                          next_erd;
  logic                          next_ord;
  logic                          next_ewr;
  logic                          next_owr;

  //////////////////////////////////////////////////////////////////////////
  dias_fifo #(
    .WIDTH (dias_pkg::FIFO_W),
    .DEPTH (dias_pkg::FIFO_D)
  ) u_wr_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (wr_data_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    req_mode = req_bank_i[1] ?
               interleave_type_i[dias_pkg::ILV_PAIR1 +: 2] :
               interleave_type_i[dias_pkg::ILV_PAIR0 +: 2];
    latched  = mode == dias_pkg::ILV_LATCH || mode == dias_pkg::ILV_REG;
    step     = p16 ? dias_pkg::STEP_16 : dias_pkg::STEP_32;
    next_state   = state;
    next_cnt     = cnt;
    next_word    = word;
    next_last    = last;
    next_col     = col;
    next_bank    = bank;
    next_mode    = mode;
    next_byte_en = byte_en;
    next_wr      = wr;
    next_p16     = p16;
    next_pmode   = pmode;
    next_skip    = skip;
    pop          = 1'b0;
    sample       = 1'b0;
    advance      = 1'b0;
    case (state)
      dias_pkg::ST_IDLE: begin
        if (req_i) begin
          next_state   = dias_pkg::ST_ROW;
          next_word    = 3'h0;
          next_col     = req_col_i;
          next_bank    = req_bank_i;
          next_mode    = req_mode;
          next_byte_en = req_byte_en_i;
          next_wr      = req_write_i;
          next_p16     = req_port16_i;
          // interleaved timing only on 32-bit reads of interleaved pairs
          next_pmode   = !req_write_i && !req_port16_i &&
                         req_mode != dias_pkg::ILV_NONE &&
                         (req_burst_i ||
                          ((req_mode == dias_pkg::ILV_LATCH ||
                            req_mode == dias_pkg::ILV_REG) &&
                           req_bank_i[0]));
          // odd single read of a latched or registered pair runs as word two of a burst
          next_skip    = !req_write_i && !req_port16_i && !req_burst_i &&
                         req_bank_i[0] &&
                         (req_mode == dias_pkg::ILV_LATCH ||
                          req_mode == dias_pkg::ILV_REG);
          // even 32-bit single read is a lone first word
          if (next_skip) begin
            next_last = dias_pkg::LAST_TWO;
          end else if (req_port16_i) begin
            if (req_burst_i) begin
              next_last = dias_pkg::LAST_BURST8;
            end else if (req_size_i == dias_pkg::SIZE_TRI ||
                         req_size_i == dias_pkg::SIZE_WORD) begin
              next_last = dias_pkg::LAST_TWO;
            end else begin
              next_last = dias_pkg::LAST_ONE;
            end
          end else if (req_burst_i &&
                       (!req_write_i || req_mode == dias_pkg::ILV_NONE)) begin
            next_last = dias_pkg::LAST_BURST4;
          end else begin
            next_last = dias_pkg::LAST_ONE;
          end
        end
      end
      dias_pkg::ST_ROW: begin
        next_state = dias_pkg::ST_SETUP;
      end
      dias_pkg::ST_SETUP: begin
        if (!wr || fifo_valid) begin
          pop        = wr;
          next_state = dias_pkg::ST_STROBE;
          next_cnt   = 2'h0;
        end
      end
      dias_pkg::ST_STROBE, dias_pkg::ST_HOLD: begin
        if (cnt == dias_pkg::CAS_LAST) begin
          sample  = !wr;
          advance = 1'b1;
        end else begin
          next_cnt = 2'(cnt + 1'b1);
        end
      end
      dias_pkg::ST_LATCH: begin
        sample  = 1'b1;
        advance = 1'b1;
      end
      dias_pkg::ST_END: begin
        next_state = dias_pkg::ST_IDLE;
      end
      default: begin
        next_state = dias_pkg::ST_IDLE;
      end
    endcase
    if (advance) begin
      next_cnt = 2'h0;
      if (word == last) begin
        next_state = dias_pkg::ST_END;
      end else begin
        next_word = 3'(word + 1'b1);
        if (pmode && next_word[0] && mode == dias_pkg::ILV_XCVR) begin
          next_state = dias_pkg::ST_HOLD;
        end else if (pmode && next_word[0]) begin
          next_state = dias_pkg::ST_LATCH;
        end else if (pmode && latched) begin
          next_col   = col + step;
          next_state = dias_pkg::ST_STROBE;
        end else begin
          next_col   = col + step;
          next_state = dias_pkg::ST_SETUP;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs follow the next state so that each leaves a flip-flop
  for (genvar g = 0; g < 4; g++) begin : g_row
    assign row_sel[g] = (next_bank == 2'(g)) ||
                        (next_pmode && next_bank[1] == 1'(g / 2));
  end

  always_comb begin
    n_dp  = next_state == dias_pkg::ST_SETUP ||
            next_state == dias_pkg::ST_STROBE ||
            next_state == dias_pkg::ST_HOLD ||
            next_state == dias_pkg::ST_LATCH;
    n_cas = n_dp && next_state != dias_pkg::ST_SETUP;
    n_odd = next_pmode ? next_word[0] : next_bank[0];
    next_busy   = next_state != dias_pkg::ST_IDLE;
    next_cas_o  = n_cas ? (next_wr ? next_byte_en : 4'hF) : 4'h0;
    next_addr_o = (state == dias_pkg::ST_IDLE && req_i) ? req_row_i :
                  next_col;
    next_data_o = pop ? fifo_data : system_data_bus_o;
    next_frame  = (n_dp || next_state == dias_pkg::ST_ROW) &&
                  next_word != next_last;
    next_rvalid = sample && !(skip && word == 3'h0);
    next_ready  = next_rvalid || pop;
    next_ewr    = 1'b0;
    next_owr    = 1'b0;
    next_erd    = 1'b0;
    next_ord    = 1'b0;
    if (next_wr) begin
      // one write enable, chosen by bank parity
      if (next_mode == dias_pkg::ILV_XCVR) begin
        next_ewr = n_dp && !n_odd;
        next_owr = n_dp && n_odd;
        next_erd = n_dp && !n_odd;
        next_ord = n_dp && n_odd;
      end else begin
        next_ewr = n_cas && !n_odd;
        next_owr = n_cas && n_odd;
      end
    end else begin
      case (next_mode)
        dias_pkg::ILV_LATCH: begin
          next_erd = next_state == dias_pkg::ST_STROBE && !n_odd;
          next_ord = n_dp;
        end
        default: begin
          next_erd = n_dp && !n_odd;
          next_ord = n_dp && n_odd;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state                    <= dias_pkg::ST_IDLE;
      cnt                      <= 2'h0;
      word                     <= 3'h0;
      last                     <= 3'h0;
      col                      <= dias_pkg::ADDR_RST;
      bank                     <= 2'h0;
      mode                     <= dias_pkg::ILV_NONE;
      byte_en                  <= 4'h0;
      wr                       <= 1'b0;
      p16                      <= 1'b0;
      pmode                    <= 1'b0;
      skip                     <= 1'b0;
      busy_o                   <= 1'b0;
      row_strobe_o             <= dias_pkg::STRB_RST;
      column_strobe_o          <= dias_pkg::STRB_RST;
      system_address_bus_o     <= dias_pkg::ADDR_RST;
      system_data_bus_o        <= dias_pkg::DATA_RST;
      data_out_en_o            <= 1'b0;
      burst_frame_o            <= 1'b0;
      data_ready_o             <= 1'b0;
      read_data_o              <= dias_pkg::DATA_RST;
      read_valid_o             <= 1'b0;
      even_bank_read_enable_o  <= 1'b0;
      odd_bank_read_enable_o   <= 1'b0;
      even_bank_write_enable_o <= 1'b0;
      odd_bank_write_enable_o  <= 1'b0;
    end else begin
      state                    <= next_state;
      cnt                      <= next_cnt;
      word                     <= next_word;
      last                     <= next_last;
      col                      <= next_col;
      bank                     <= next_bank;
      mode                     <= next_mode;
      byte_en                  <= next_byte_en;
      wr                       <= next_wr;
      p16                      <= next_p16;
      pmode                    <= next_pmode;
      skip                     <= next_skip;
      busy_o                   <= next_busy;
      row_strobe_o             <= (next_busy &&
                                   next_state != dias_pkg::ST_END) ?
                                  row_sel : 4'h0;
      column_strobe_o          <= next_cas_o;
      system_address_bus_o     <= next_addr_o;
      system_data_bus_o        <= next_data_o;
      data_out_en_o            <= next_wr && n_dp;
      burst_frame_o            <= next_frame;
      data_ready_o             <= next_ready;
      read_data_o              <= sample ? dram_data_i : read_data_o;
      read_valid_o             <= next_rvalid;
      even_bank_read_enable_o  <= next_erd;
      odd_bank_read_enable_o   <= next_ord;
      even_bank_write_enable_o <= next_ewr;
      odd_bank_write_enable_o  <= next_owr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_we_onehot: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (column_strobe_o != 4'h0 && wr) |->
    $onehot({even_bank_write_enable_o, odd_bank_write_enable_o}))
    else $error("write strobe without exactly one write enable");

  a_frame_last: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (state == dias_pkg::ST_STROBE && word == last) |-> !burst_frame_o)
    else $error("burst frame still high on final word");

  a_xcvr_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (state == dias_pkg::ST_STROBE && next_state == dias_pkg::ST_HOLD) |=>
    ($stable(system_address_bus_o) && $stable(column_strobe_o)))
    else $error("column moved on held odd word");

  a_xcvr_save: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(state == dias_pkg::ST_HOLD) |->
    (state == dias_pkg::ST_HOLD) [*2] ##1 (state != dias_pkg::ST_HOLD))
    else $error("held odd word not two clocks");

  a_latch_step: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (state == dias_pkg::ST_LATCH && word != last) |=>
    (state == dias_pkg::ST_STROBE && column_strobe_o == 4'hF))
    else $error("even column not pipelined after latch");

  a_mux_ctrl: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (mode == dias_pkg::ILV_LATCH && !wr && state == dias_pkg::ST_LATCH) |->
    (odd_bank_read_enable_o && !even_bank_read_enable_o))
    else $error("mux enables wrong during latched word");

  a_reg_direct: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (mode == dias_pkg::ILV_REG && !wr && pmode &&
     state == dias_pkg::ST_LATCH) |->
    (odd_bank_read_enable_o && !even_bank_read_enable_o))
    else $error("registered enables not direct");

  a_odd_skip: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (skip && state == dias_pkg::ST_STROBE && word == 3'h0 &&
     cnt == dias_pkg::CAS_LAST) |=> !read_valid_o)
    else $error("dummy first word returned");

  a_addr_step: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ($changed(word) && word != 3'h0 && !pmode) |->
    col == $past(col) + step)
    else $error("column step wrong");

  a_write_data: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    pop |=> (system_data_bus_o == $past(fifo_data) && data_ready_o))
    else $error("write phase data not driven");

endmodule : dias_seq
`default_nettype wire

// ===== test/dias_dram_model.sv
// Purpose: dram bank pair model behind the external data path
// Assumes: a word is coded from the column address while strobed
// Notes:   an unstrobed bus shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module dias_dram_model (
  input  wire logic        ref_clk_i,
  input  wire logic [3:0]  column_strobe_i,
  input  wire logic [25:0] col_i,
  output logic      [31:0] data_o
);
  initial data_o = 32'h0;
  always @(posedge ref_clk_i) begin
    if (column_strobe_i != 4'h0) begin
      data_o <= {6'h15, col_i};
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : dias_dram_model
`default_nettype wire

// ===== test/dias_seq_tb.sv
// Purpose: self-checking bench of the interleaved access sequencer
// Assumes: the dram model returns a column-coded word
// Notes:   drivers queue expected words, a monitor compares them
`timescale 1ns/100ps
`default_nettype none
module dias_seq_tb;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0;
  logic        req_write_i = 1'b0, req_port16_i = 1'b0, req_burst_i = 1'b0;
  logic        wr_valid_i = 1'b0, wmode = 1'b0, cs_prev = 1'b0;
  logic [1:0]  req_size_i = 2'h0, req_bank_i = 2'h0;
  logic [3:0]  interleave_type_i = 4'h0, be = 4'hF;
  logic [25:0] req_row_i = 26'h0, req_col_i = 26'h0, rq[$], aq[$];
  logic [31:0] wr_data_i = 32'h0, wq[$];
  wire  logic  wr_ready_o, busy_o, rvalid, ewe, owe, doe, bf;
  wire  logic [3:0]  cs, rs;
  wire  logic [25:0] sab;
  wire  logic [31:0] dram_data_i, sdb, rdata;
  int          bad_count = 0, compares = 0, cycles = 0, du, d[4];
  always #5 ref_clk_i = ~ref_clk_i;
  dias_dram_model model (.ref_clk_i(ref_clk_i), .column_strobe_i(cs),
    .col_i(sab), .data_o(dram_data_i));
  dias_seq dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_port16_i(req_port16_i),
    .req_size_i(req_size_i), .req_burst_i(req_burst_i),
    .req_bank_i(req_bank_i), .req_byte_en_i(be), .req_row_i(req_row_i),
    .req_col_i(req_col_i), .interleave_type_i(interleave_type_i),
    .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .dram_data_i(dram_data_i), .busy_o(busy_o), .row_strobe_o(rs),
    .column_strobe_o(cs), .system_address_bus_o(sab),
    .system_data_bus_o(sdb), .data_out_en_o(doe), .burst_frame_o(bf),
    .data_ready_o(), .read_data_o(rdata), .read_valid_o(rvalid),
    .even_bank_read_enable_o(), .odd_bank_read_enable_o(),
    .even_bank_write_enable_o(ewe), .odd_bank_write_enable_o(owe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic go(logic w, logic p, logic [1:0] sz, logic bu,
                    logic [1:0] bk, logic [3:0] it, int n, output int dur);
    logic [25:0] c;
    logic        il;
    c = 26'($urandom) & 26'h0FFFFF0;
    il = !w && !p && it[2*bk[1] +: 2] != 2'h0;
    for (int k = 0; k < n; k++) begin
      if (w) aq.push_back(c + 26'(k * (p ? 2 : 4)));
      else rq.push_back(c + 26'(4 * (il ? k >> 1 : k)));
    end
    wmode = w;
    req_i <= 1'b1;
    req_write_i <= w;
    req_port16_i <= p;
    req_size_i <= sz;
    req_burst_i <= bu;
    req_bank_i <= bk;
    req_col_i <= c;
    req_row_i <= 26'($urandom);
    interleave_type_i <= it;
    be <= w ? 4'($urandom_range(15, 1)) : 4'hF;
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    dur = 0;
    do begin
      @(posedge ref_clk_i);
      dur++;
    end while (busy_o !== 1'b0);
    @(posedge ref_clk_i);
  endtask : go
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      finish_test();
    end
  end
  always @(posedge ref_clk_i) begin
    if (rvalid === 1'b1) begin
      check(rdata, {6'h15, rq.pop_front()});
    end
    if (wmode && cs !== 4'h0 && !cs_prev) begin
      check(sdb, wq.pop_front());
      check(32'(sab), 32'(aq.pop_front()));
      check(32'(bf), 32'(aq.size() != 0));
      check(32'(cs), 32'(be));
      check(32'({rs, doe}), 32'({4'(1 << req_bank_i), 1'b1}));
      check(32'(ewe ^ owe), 32'h1);
    end
    cs_prev <= cs !== 4'h0;
  end
  initial begin
    void'($urandom(32'h1F90));
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      for (int t = 0; t < 4; t++) begin
        go(0, 0, 2'h3, 1, 2'(2 * p), 4'(t << (2 * p)), 4, d[t]);
        go(0, 0, 2'h3, 0, 2'(t ^ p), 4'(t * 5), 1, du);
      end
      check(32'(d[0] - d[1]), 32'h2);
      check(32'(d[0] - d[2] >= 3), 32'h1);
      check(32'(d[0] - d[3] >= 3), 32'h1);
    end
    wr_valid_i <= 1'b1;
    wr_data_i <= $urandom;
    for (int i = 0; i < 40 && wq.size() < 16; i++) begin
      @(posedge ref_clk_i);
      if (wr_ready_o === 1'b1) begin
        wq.push_back(wr_data_i);
        wr_data_i <= $urandom;
      end
    end
    wr_valid_i <= 1'b0;
    @(posedge ref_clk_i);
    check(32'(wr_ready_o), 32'h0);
    go(1, 1, 2'h3, 1, 2'h0, 4'h0, 8, du);
    go(1, 0, 2'h3, 1, 2'h1, 4'h0, 4, du);
    go(1, 1, 2'h3, 0, 2'h2, 4'h5, 2, du);
    go(1, 1, 2'h2, 0, 2'h3, 4'hF, 2, du);
    check(32'(wq.size() + rq.size() + aq.size()), 32'h0);
    check(32'(wr_ready_o), 32'h1);
    finish_test();
  end
endmodule : dias_seq_tb
`default_nettype wire
